// file: rtl/asl_pkg.sv
// Shared constants, types and helpers of the accumulator shift and limit path
package asl_pkg;

  // ==========================================================
  // Widths
  localparam int WORD_W  = 24;
  localparam int GUARD_W = 8;
  localparam int LONG_W  = 48;
  localparam int ACC_W   = 56;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_A_HI = 8'h08;
  localparam logic [7:0] OFS_A_LO = 8'h0c;
  localparam logic [7:0] OFS_B_HI = 8'h10;
  localparam logic [7:0] OFS_B_LO = 8'h14;

  // Field positions and reset values
  localparam int CTRL_SCALE_LSB  = 0;
  localparam int CTRL_OP_LSB     = 2;
  localparam int CTRL_ASEL_BIT   = 5;
  localparam int STAT_LIMIT_BIT  = 0;
  localparam int STAT_GUARD_A    = 1;
  localparam int STAT_GUARD_B    = 2;
  localparam logic [1:0] SCALE_RST = 2'h0;
  localparam logic [2:0] OP_RST    = 3'h0;

  // Saturation constants, upper and lower halves
  localparam logic [23:0] SAT_POS_HI = 24'h7fffff;
  localparam logic [23:0] SAT_NEG_HI = 24'h800000;
  localparam logic [23:0] SAT_POS_LO = 24'hffffff;
  localparam logic [23:0] SAT_NEG_LO = 24'h000000;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {asl_sc_none, asl_sc_down, asl_sc_up, asl_sc_rsvd} asl_sc_t;
  typedef enum logic [2:0] {asl_op_pass, asl_op_asl, asl_op_lsl, asl_op_rol,
                            asl_op_asr, asl_op_lsr, asl_op_ror, asl_op_zero} asl_op_t;
  typedef enum logic [1:0] {asl_src_full, asl_src_guard, asl_src_upper, asl_src_lower} asl_src_t;
  typedef enum logic [2:0] {asl_wr_word, asl_wr_long, asl_wr_guard, asl_wr_upper,
                            asl_wr_lower, asl_wr_none1, asl_wr_none2, asl_wr_none3} asl_wr_t;

  // ==========================================================
  // Guard bits count as used when they and the upper word MSB disagree
  function automatic logic guard_used(input logic [55:0] v);
    guard_used = !((&v[55:47]) || !(|v[55:47]));
  endfunction

endpackage

// file: rtl/asl_lane_if.sv
// Carrier between the top and one output shifter/limiter lane
`timescale 1ns/1ns
interface asl_lane_if;
  import asl_pkg::*;
  logic [55:0] acc;
  asl_sc_t     scale;
  asl_src_t    src;
  logic        lo_half;
  logic [23:0] data;
  logic        ovf;
  logic        sat;
  modport lane (input acc, input scale, input src, input lo_half, output data, output ovf, output sat);
  modport ctrl (output acc, output scale, output src, output lo_half, input data, input ovf, input sat);
endinterface

// file: rtl/asl_acc_shifter.sv
// Combinational 56-bit operand shifter ahead of the accumulate adder
`timescale 1ns/1ns
module asl_acc_shifter
  import asl_pkg::*;
(
  input  wire logic [55:0] din,
  input  wire asl_op_t     op,
  output logic      [55:0] dout
);

  // ==========================================================
  // One-bit shifts; in 56 bits a logical and arithmetic left shift agree
  always_comb begin
    case (op)
      asl_op_pass: dout = din;
      asl_op_asl:  dout = {din[54:0], 1'b0};
      asl_op_lsl:  dout = {din[54:0], 1'b0};
      asl_op_rol:  dout = {din[54:0], din[55]};
      asl_op_asr:  dout = {din[55], din[55:1]};
      asl_op_lsr:  dout = {1'b0, din[55:1]};
      asl_op_ror:  dout = {din[0], din[55:1]};
      asl_op_zero: dout = '0;
      default:     dout = din;
    endcase
  end

endmodule

// file: rtl/asl_limit_lane.sv
// One output lane: scaling shifter followed by a saturation limiter
`timescale 1ns/1ns
module asl_limit_lane
  import asl_pkg::*;
(
  asl_lane_if.lane lp
);

  logic [55:0] sh;
  logic [23:0] sub;

  // ==========================================================
  // Scaling shift; the reserved code behaves as no shift
  always_comb begin
    case (lp.scale)
      asl_sc_up:   sh = {lp.acc[54:0], 1'b0};
      asl_sc_down: sh = {lp.acc[55], lp.acc[55:1]};
      default:     sh = lp.acc;
    endcase
  end

  // Sub-register reads, guard byte returned sign extended
  always_comb begin
    case (lp.src)
      asl_src_guard: sub = {{16{lp.acc[55]}}, lp.acc[55:48]};
      asl_src_upper: sub = lp.acc[47:24];
      default:       sub = lp.acc[23:0];
    endcase
  end

  // Overflow is judged on the shifted value, so limiting follows scaling
  assign lp.ovf = (lp.src == asl_src_full) && guard_used(sh);
  assign lp.sat = lp.ovf;

  // ==========================================================
  // Substitute a constant signed by the guard MSB, else pass unchanged
  always_comb begin
    if (lp.src != asl_src_full) begin
      lp.data = sub;
    end else if (!lp.ovf) begin
      lp.data = lp.lo_half ? sh[23:0] : sh[47:24];
    end else if (lp.lo_half) begin
      lp.data = lp.acc[55] ? SAT_NEG_LO : SAT_POS_LO;
    end else begin
      lp.data = lp.acc[55] ? SAT_NEG_HI : SAT_POS_HI;
    end
  end

endmodule

// file: rtl/asl_path.sv
// Accumulator pair with operand shifter, two bus shifter/limiters and APB control
//
// Notes on behaviour
// - Adder operand path shifter: pass, one-bit left or right shift or rotate, or zero.
// - Each data bus has its own shifter followed by a limiter.
// - Overflow of the shifted value out of the destination is detected per lane.
// - Limiting happens only with guard bits in use on a full accumulator read.
// - A value that fits passes shifted but otherwise unchanged.
// - Positive overflow gives 7fffff, or 7fffff ffffff for long reads.
// - Negative overflow gives 800000, or 800000 000000 for long reads.
// - Constant sign comes from the top guard bit, size from the destination.
// - Shifting and limiting never change the stored accumulators.
// - Any substitution sets a sticky limit flag until software clears it.
// - Two lanes limit independently, or jointly as one 48-bit limiter.
// - Guard, upper and lower sub-register reads bypass shift and limit.
// - Output shifters shift left, right or not, per the scaling bits.
// - Each lane gives a 24-bit result and an overflow indication.
// - A word write loads the upper word, sign-fills guard, clears lower.
// - A long write puts low half in lower word, high half in upper.
// - Saturation is applied after the scaling shift.
// - Writing a single sub-register does not sign extend elsewhere.
`timescale 1ns/1ns
module asl_path
  import asl_pkg::*;
#(
  parameter int DATA_W = WORD_W
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rd1_en,
  input  wire logic        rd1_acc_b,
  input  wire asl_src_t    rd1_src,
  input  wire logic        rd2_en,
  input  wire logic        rd2_acc_b,
  input  wire asl_src_t    rd2_src,
  input  wire logic        rd_long,
  input  wire logic        rd_long_acc_b,
  output logic      [23:0] first_data_bus,
  output logic             first_data_vld,
  output logic      [23:0] second_data_bus,
  output logic             second_data_vld,
  input  wire logic        wr_en,
  input  wire logic        wr_acc_b,
  input  wire asl_wr_t     wr_kind,
  input  wire logic [47:0] wr_data,
  input  wire logic        res_en,
  input  wire logic        res_acc_b,
  input  wire logic [55:0] res_val,
  output logic      [55:0] mac_opnd,
  output logic             limit_flag
);

  // ==========================================================
  // Elaboration check: lanes are built for 24-bit words only
  if (DATA_W != WORD_W) begin : g_bad_width
    $error("asl_path supports only 24-bit data words");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [55:0] acc_a;
    logic [55:0] acc_b;
    logic [55:0] opnd;
    logic [23:0] bus1;
    logic [23:0] bus2;
    logic        vld1;
    logic        vld2;
    logic [1:0]  scale;
    logic [2:0]  op;
    logic        op_sel_b;
    logic        limit;
    logic [31:0] rdata;
    logic        err;
  } asl_state_t;

  asl_state_t  s_q;
  asl_state_t  s_d;
  asl_lane_if  lane1 ();
  asl_lane_if  lane2 ();
  logic [55:0] shift_out;
  logic        setup;
  logic        access_wr;
  logic        mapped;
  logic        sat_hit;

  // ==========================================================
  // Lane steering: a long read joins both lanes on one accumulator
  assign lane1.acc     = (rd_long ? rd_long_acc_b : rd1_acc_b) ? s_q.acc_b : s_q.acc_a;
  assign lane2.acc     = (rd_long ? rd_long_acc_b : rd2_acc_b) ? s_q.acc_b : s_q.acc_a;
  assign lane1.src     = rd_long ? asl_src_full : rd1_src;
  assign lane2.src     = rd_long ? asl_src_full : rd2_src;
  assign lane1.lo_half = 1'b0;
  assign lane2.lo_half = rd_long;
  assign lane1.scale   = asl_sc_t'(s_q.scale);
  assign lane2.scale   = asl_sc_t'(s_q.scale);

  // Two independent lanes, one per data bus
  asl_limit_lane u_lane1 (.lp(lane1));
  asl_limit_lane u_lane2 (.lp(lane2));

  // Adder operand shifter reads, never writes, the chosen accumulator
  asl_acc_shifter u_acc_shift (
    .din  (s_q.op_sel_b ? s_q.acc_b : s_q.acc_a),
    .op   (asl_op_t'(s_q.op)),
    .dout (shift_out)
  );

  // ==========================================================
  // Bus decode; zero wait states, so pready follows penable
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign mapped    = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_A_HI) ||
                     (paddr == OFS_A_LO) || (paddr == OFS_B_HI) || (paddr == OFS_B_LO);

  // A limit event on a lane that is actually driving its bus
  assign sat_hit = ((rd1_en || rd_long) && lane1.sat) || ((rd2_en || rd_long) && lane2.sat);

  // ==========================================================
  // Next state
  always_comb begin
    logic [55:0] t;
    t   = wr_acc_b ? s_q.acc_b : s_q.acc_a;
    s_d = s_q;

    // Bus outputs: a long read takes both lanes in the same cycle
    s_d.vld1 = rd1_en || rd_long;
    s_d.vld2 = rd2_en || rd_long;
    if (rd1_en || rd_long) begin
      s_d.bus1 = lane1.data;
    end
    if (rd2_en || rd_long) begin
      s_d.bus2 = lane2.data;
    end
    s_d.opnd = shift_out;

    // Arithmetic results land first; a bus write in the same cycle wins
    if (res_en) begin
      if (res_acc_b) begin
        s_d.acc_b = res_val;
      end else begin
        s_d.acc_a = res_val;
      end
    end
    if (wr_en) begin
      case (wr_kind)
        asl_wr_word:  t = {{8{wr_data[23]}}, wr_data[23:0], 24'h000000};
        asl_wr_long:  t = {{8{wr_data[47]}}, wr_data[47:24], wr_data[23:0]};
        asl_wr_guard: t[55:48] = wr_data[7:0];
        asl_wr_upper: t[47:24] = wr_data[23:0];
        asl_wr_lower: t[23:0]  = wr_data[23:0];
        default:      t = t;
      endcase
      if (wr_acc_b) begin
        s_d.acc_b = t;
      end else begin
        s_d.acc_a = t;
      end
    end

    // Register writes; status bit is write-one-to-clear
    if (access_wr) begin
      if (paddr == OFS_CTRL) begin
        s_d.scale    = pwdata[CTRL_SCALE_LSB +: 2];
        s_d.op       = pwdata[CTRL_OP_LSB +: 3];
        s_d.op_sel_b = pwdata[CTRL_ASEL_BIT];
      end else if ((paddr == OFS_STAT) && pwdata[STAT_LIMIT_BIT]) begin
        s_d.limit = 1'b0;
      end
    end
    // A new limit event beats a clear in the same cycle
    if (sat_hit) begin
      s_d.limit = 1'b1;
    end

    // Read data captured in the setup cycle, shown in the access cycle
    if (setup) begin
      s_d.err   = !mapped;
      s_d.rdata = 32'h00000000;
      case (paddr)
        OFS_CTRL: begin
          s_d.rdata[CTRL_SCALE_LSB +: 2] = s_q.scale;
          s_d.rdata[CTRL_OP_LSB +: 3]    = s_q.op;
          s_d.rdata[CTRL_ASEL_BIT]       = s_q.op_sel_b;
        end
        OFS_STAT: begin
          s_d.rdata[STAT_LIMIT_BIT] = s_q.limit;
          s_d.rdata[STAT_GUARD_A]   = guard_used(s_q.acc_a);
          s_d.rdata[STAT_GUARD_B]   = guard_used(s_q.acc_b);
        end
        OFS_A_HI: s_d.rdata = s_q.acc_a[55:24];
        OFS_A_LO: s_d.rdata = {8'h00, s_q.acc_a[23:0]};
        OFS_B_HI: s_d.rdata = s_q.acc_b[55:24];
        OFS_B_LO: s_d.rdata = {8'h00, s_q.acc_b[23:0]};
        default:  s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '{acc_a: '0, acc_b: '0, opnd: '0, bus1: '0, bus2: '0, vld1: 1'b0, vld2: 1'b0,
               scale: SCALE_RST, op: OP_RST, op_sel_b: 1'b0, limit: 1'b0,
               rdata: '0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs; accumulators are only ever changed by writes and results
  assign prdata          = s_q.rdata;
  assign pready          = psel && penable;
  assign pslverr         = psel && penable && s_q.err;
  assign first_data_bus  = s_q.bus1;
  assign first_data_vld  = s_q.vld1;
  assign second_data_bus = s_q.bus2;
  assign second_data_vld = s_q.vld2;
  assign mac_opnd        = s_q.opnd;
  assign limit_flag      = s_q.limit;

endmodule

// file: tb/asl_path_properties.sv
// Port-level timing checker of the accumulator shift and limit path
`timescale 1ns/1ns
module asl_path_properties
  import asl_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rd1_en,
  input wire logic        rd2_en,
  input wire logic        rd_long,
  input wire logic        first_data_vld,
  input wire logic        second_data_vld,
  input wire logic [55:0] mac_opnd,
  input wire logic        limit_flag
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic stat_clr = psel && penable && pwrite && paddr == OFS_STAT && pwdata[STAT_LIMIT_BIT];
  wire logic rd_any   = rd1_en || rd2_en || rd_long;
  logic      rd_any_q;

  // A read one cycle back is the only legal cause of a new limit flag
  always_ff @(posedge clock) begin
    rd_any_q <= resetn && rd_any;
  end

  // ==========================================================
  // Properties
  a_pready_zero: assert property (pready == (psel && penable)) else $error("pready not zero wait");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  a_err_unmapped: assert property ((psel && !penable && paddr[7:5] != 3'h0) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access without error");
  a_first_vld: assert property ((rd1_en || rd_long) |=> first_data_vld) else $error("first lane no valid");
  a_second_idle: assert property (!(rd2_en || rd_long) |=> !second_data_vld) else $error("second lane stray");
  a_long_pair: assert property (rd_long |=> first_data_vld && second_data_vld) else $error("long read split");
  a_limit_sticky: assert property (limit_flag && !stat_clr |=> limit_flag) else $error("limit flag lost");
  a_limit_clear: assert property (stat_clr && !rd_any |=> !limit_flag) else $error("limit flag not cleared");
  a_limit_cause: assert property ($rose(limit_flag) |-> rd_any_q) else $error("limit flag without read");
  a_mac_zero: assert property (
    psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_OP_LSB +: 3] == 3'h7
    |-> ##2 mac_opnd == 56'h0) else $error("operand not forced to zero");
endmodule

bind asl_path asl_path_properties u_props (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .rd1_en, .rd2_en, .rd_long, .first_data_vld, .second_data_vld, .mac_opnd, .limit_flag);

// file: tb/asl_bus_sink.sv
// Receiver model at the far side of the two data buses
`timescale 1ns/1ns
module asl_bus_sink (
  input  wire logic        clock,
  input  wire logic [23:0] bus1,
  input  wire logic        vld1,
  input  wire logic [23:0] bus2,
  input  wire logic        vld2,
  output logic      [23:0] got1,
  output logic      [23:0] got2
);
  // Take a word only on its valid pulse; a held bus is never read twice
  always_ff @(posedge clock) begin
    if (vld1) got1 <= bus1;
    if (vld2) got2 <= bus2;
  end
endmodule

// file: tb/test_accumulator_shift_limit_path.sv
// Directed bench of the accumulator shift and limit path
`timescale 1ns/1ns
module test_accumulator_shift_limit_path;
  import asl_pkg::*;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        rd1_en, rd1_acc_b, rd2_en, rd2_acc_b, rd_long, rd_long_acc_b;
  asl_src_t    rd1_src, rd2_src;
  logic [23:0] first_data_bus, second_data_bus, got1, got2;
  logic        first_data_vld, second_data_vld, wr_en, wr_acc_b, res_en, res_acc_b, limit_flag;
  asl_wr_t     wr_kind;
  logic [47:0] wr_data;
  logic [55:0] res_val, mac_opnd;
  int          bad_count, checks;

  asl_path DUT (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rd1_en, .rd1_acc_b, .rd1_src, .rd2_en, .rd2_acc_b, .rd2_src, .rd_long, .rd_long_acc_b,
    .first_data_bus, .first_data_vld, .second_data_bus, .second_data_vld, .wr_en, .wr_acc_b,
    .wr_kind, .wr_data, .res_en, .res_acc_b, .res_val, .mac_opnd, .limit_flag
  );
  asl_bus_sink sink (.clock, .bus1(first_data_bus), .vld1(first_data_vld), .bus2(second_data_bus),
                     .vld2(second_data_vld), .got1, .got2);

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Tests take under 500 cycles; 5000 leaves room without hiding a hang
  initial begin
    #100000;
    bad_count++;
    final_report;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // APB transfer; d is write data or expected read data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    chk(56'(pslverr), 56'(err));
    if (!wr) chk(56'(prdata), 56'(d));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Word, long or sub-register write (r low) or arithmetic result load (r high)
  task automatic ld(input logic b, input asl_wr_t k, input logic [47:0] d, input logic r, input logic [55:0] v);
    @(posedge clock);
    wr_en <= !r;
    res_en <= r;
    wr_acc_b <= b;
    res_acc_b <= b;
    wr_kind <= k;
    wr_data <= d;
    res_val <= v;
    @(posedge clock);
    wr_en <= 1'b0;
    res_en <= 1'b0;
  endtask

  task automatic ca(input logic b, input logic [31:0] hi, input logic [31:0] lo);
    apb(1'b0, b ? OFS_B_HI : OFS_A_HI, hi, 1'b0);
    apb(1'b0, b ? OFS_B_LO : OFS_A_LO, lo, 1'b0);
  endtask

  // Both lanes read in one cycle; the sink shows them two edges later
  task automatic rd(input logic b1, input asl_src_t s1, input logic b2, input asl_src_t s2, input logic lng,
                    input logic [23:0] e1, input logic [23:0] e2);
    @(posedge clock);
    rd1_en <= 1'b1;
    rd2_en <= 1'b1;
    rd1_acc_b <= b1;
    rd2_acc_b <= b2;
    rd_long_acc_b <= b1;
    rd1_src <= s1;
    rd2_src <= s2;
    rd_long <= lng;
    @(posedge clock);
    rd1_en <= 1'b0;
    rd2_en <= 1'b0;
    rd_long <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(56'(got1), 56'(e1));
    chk(56'(got2), 56'(e2));
  endtask

  task automatic flag(input logic e);
    @(negedge clock);
    chk(56'(limit_flag), 56'(e));
  endtask

  function automatic logic [55:0] exp_op(input logic [2:0] op, input logic [55:0] v);
    case (op)
      3'h0: return v;
      3'h1, 3'h2: return v << 1;
      3'h3: return {v[54:0], v[55]};
      3'h4: return {v[55], v[55:1]};
      3'h5: return v >> 1;
      3'h6: return {v[0], v[55:1]};
      default: return 56'h0;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, rd1_en, rd2_en, rd_long} = '0;
    {rd1_acc_b, rd2_acc_b, rd_long_acc_b, wr_en, wr_acc_b, wr_data, res_en, res_acc_b, res_val} = '0;
    rd1_src = asl_src_full;
    rd2_src = asl_src_full;
    wr_kind = asl_wr_word;
    bad_count = 0;
    checks = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0, 1'b0);
    ld(1'b0, asl_wr_word, 48'h400000, 1'b0, '0);
    ld(1'b1, asl_wr_word, 48'h800000, 1'b0, '0);
    ca(1'b0, 32'h00400000, 32'h0);
    ca(1'b1, 32'hff800000, 32'h0);
    rd(1'b0, asl_src_full, 1'b1, asl_src_full, 1'b0, 24'h400000, 24'h800000);
    flag(1'b0);
    apb(1'b1, OFS_CTRL, 32'h2, 1'b0);
    rd(1'b0, asl_src_full, 1'b1, asl_src_full, 1'b0, SAT_POS_HI, SAT_NEG_HI);
    flag(1'b1);
    apb(1'b0, OFS_STAT, 32'h1, 1'b0);
    rd(1'b0, asl_src_upper, 1'b1, asl_src_guard, 1'b0, 24'h400000, 24'hffffff);
    ca(1'b0, 32'h00400000, 32'h0);
    apb(1'b1, OFS_STAT, 32'h1, 1'b0);
    flag(1'b0);
    apb(1'b1, OFS_CTRL, 32'h1, 1'b0);
    rd(1'b0, asl_src_full, 1'b1, asl_src_full, 1'b0, 24'h200000, 24'hc00000);
    apb(1'b1, OFS_CTRL, 32'h3, 1'b0);
    rd(1'b0, asl_src_full, 1'b1, asl_src_full, 1'b0, 24'h400000, 24'h800000);
    flag(1'b0);
    apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    ld(1'b0, asl_wr_none1, '0, 1'b1, 56'h01_234567_89abcd);
    rd(1'b0, asl_src_full, 1'b0, asl_src_full, 1'b1, SAT_POS_HI, SAT_POS_LO);
    apb(1'b0, OFS_STAT, 32'h3, 1'b0);
    ld(1'b1, asl_wr_none1, '0, 1'b1, 56'hfe_dcba98_765432);
    rd(1'b1, asl_src_full, 1'b1, asl_src_full, 1'b1, SAT_NEG_HI, SAT_NEG_LO);
    ld(1'b0, asl_wr_long, 48'h800000_123456, 1'b0, '0);
    ca(1'b0, 32'hff800000, 32'h00123456);
    ld(1'b0, asl_wr_upper, 48'h7fffff, 1'b0, '0);
    ca(1'b0, 32'hff7fffff, 32'h00123456);
    ld(1'b0, asl_wr_lower, 48'h654321, 1'b0, '0);
    ld(1'b0, asl_wr_guard, 48'h12, 1'b0, '0);
    ca(1'b0, 32'h127fffff, 32'h00654321);
    ld(1'b0, asl_wr_none1, 48'h1, 1'b0, '0);
    ca(1'b0, 32'h127fffff, 32'h00654321);
    // Guard bits in use, yet sub-register reads must bypass the limiter
    rd(1'b0, asl_src_lower, 1'b0, asl_src_guard, 1'b0, 24'h654321, 24'h000012);
    apb(1'b0, 8'h40, 32'h0, 1'b1);
    // Every operand shifter mode on a value with both end bits set
    ld(1'b0, asl_wr_none1, '0, 1'b1, 56'h80_000000_000001);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CTRL, 32'(i) << CTRL_OP_LSB, 1'b0);
      @(posedge clock);
      @(negedge clock);
      chk(mac_opnd, exp_op(3'(i), 56'h80_000000_000001));
    end
    // Operand taken from accumulator B; the extra cycles let the registered operand update
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_ASEL_BIT, 1'b0);
    @(posedge clock);
    @(negedge clock);
    chk(mac_opnd, 56'hfe_dcba98_765432);
    final_report;
  end
endmodule
